// ---- src/ccc_consts.svh ----
`ifndef CCC_CONSTS_SVH
`define CCC_CONSTS_SVH
// Command identifiers (low seven bits of the command byte, bit 7 is read/write)
`define CCC_CMD_AFE 7'h31
`define CCC_CMD_TOUT 7'h32
`define CCC_CMD_GRX 7'h40
`define CCC_CMD_GTX 7'h41
`define CCC_CMD_RFC 7'h42
`define CCC_CMD_XFC 7'h43
`define CCC_CMD_BFC 7'h44
`define CCC_CMD_ZFC 7'h45
// Coefficient counts and their base index in the per-channel store
`define CCC_N_R 6'd17
`define CCC_N_X 6'd17
`define CCC_N_B 6'd26
`define CCC_N_Z 6'd5
`define CCC_BASE_R 7'd0
`define CCC_BASE_X 7'd17
`define CCC_BASE_B 7'd34
`define CCC_BASE_Z 7'd60
`define CCC_COEF_TOTAL 65
`define CCC_STAGE_WORDS 26
`define CCC_CHANNELS 4
// Field positions
`define CCC_KA_LSB 8
`define CCC_TTX_BIT 0
`define CCC_TEN_BIT 0
// Reset values
`define CCC_AFE_RST 16'hAA00
`define CCC_TOUT_RST 16'hFFFF
`define CCC_GAIN_RST 16'h4000
// Timing, in picoseconds
`define CCC_CLK_PS 5000
`define CCC_TSTEP_PS 62500
`define CCC_TOFS_PS 31240
`define CCC_STEP_HALF ((2 * `CCC_TSTEP_PS) / `CCC_CLK_PS)
`define CCC_OFS_CYC (`CCC_TOFS_PS / `CCC_CLK_PS)
`endif

// ---- src/ccc_pkg.sv ----
package ccc_pkg;
   typedef enum logic [1:0] {
      CCC_IDLE = 2'b00,
      CCC_PAYLOAD = 2'b01,
      CCC_SKIP = 2'b10
   } ccc_state_e;
   typedef logic [15:0] ccc_word_t;
   typedef logic [3:0] ccc_mask_t;
endpackage

// ---- src/ccc_command_unit.sv ----
`timescale 1ns/1ps
`include "ccc_consts.svh"
// Summary of operation
// - Metering mode bit adapts the front end for metering pulses.
// - Timeout setting resets to all ones.
// - Timeout bit 0 low disables the timeout function.
// - Timeout lasts bits 15..1 times 62.5 ns plus 31.24 ns.
// - Zero receive gain blocks the receive analog output.
// - Nonzero receive gain scales by value/32768; host keeps it at most 7FFFh.
// - Zero transmit gain puts a null level in the transmit timeslot.
// - Nonzero transmit gain scales by value/32768; host keeps it at most 7FFFh.
// - R filter load carries and stores 17 sixteen-bit coefficients.
// - X filter load carries and stores 17 sixteen-bit coefficients.
// - B filter load carries and stores 26 sixteen-bit coefficients.
// - Z filter load carries and stores 5 sixteen-bit coefficients.
// - Commands reach every channel set in the channel enable mask.
// - Front-end and timeout commands ignore the channel enable mask.
// - Front-end word holds one two-bit gain field per channel.
module ccc_command_unit (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   input wire logic clk_en,
   // Command byte stream
   input wire logic frame_start,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic cmd_done,
   input wire ccc_pkg::ccc_mask_t channel_enable_mask,
   // Front end
   output ccc_pkg::ccc_mask_t frontend_gain_enable,
   output ccc_pkg::ccc_mask_t frontend_gain_high,
   output logic metering_pulse_mode,
   // Timeout
   output ccc_pkg::ccc_word_t timeout_setting,
   output logic timeout_enable_bit,
   input wire logic timeout_start,
   output logic timeout_expired,
   // Gain paths
   input wire logic signed [15:0] rx_sample_in [4],
   input wire logic signed [15:0] tx_sample_in [4],
   output logic signed [15:0] receive_analog_output [4],
   output logic signed [15:0] pcm_transmit_output [4],
   // Coefficient readback
   input wire logic [1:0] coef_rd_chan,
   input wire logic [6:0] coef_rd_index,
   output ccc_pkg::ccc_word_t coef_rd_data
);
   import ccc_pkg::*;

   ccc_state_e state_reg, state_next;
   logic [6:0] cmd_reg, cmd_next;
   logic [5:0] cnt_reg, cnt_next;
   logic [7:0] lo_reg, lo_next;
   ccc_word_t afe_reg, afe_next;
   ccc_word_t tout_reg, tout_next;
   ccc_word_t rx_gain_reg [4];
   ccc_word_t rx_gain_next [4];
   ccc_word_t tx_gain_reg [4];
   ccc_word_t tx_gain_next [4];
   ccc_word_t stage_reg [`CCC_STAGE_WORDS];
   ccc_word_t coef_mem [`CCC_CHANNELS][`CCC_COEF_TOTAL];
   ccc_word_t word;
   ccc_word_t coef_rd_reg;
   logic last_byte, payload_byte, done_reg;
   logic commit_rx, commit_tout, commit_filter;
   logic [5:0] n_words;
   logic [6:0] base;
   logic [19:0] tmr_cnt_reg, tmr_cnt_next, tmr_target;
   logic tmr_run_reg, tmr_run_next, exp_reg, exp_next;

   // Payload length in 16-bit words, zero for commands this unit does not own
   function automatic logic [5:0] cmd_words(input logic [6:0] c);
      unique case (c)
         `CCC_CMD_AFE, `CCC_CMD_TOUT, `CCC_CMD_GRX, `CCC_CMD_GTX: cmd_words = 6'd1;
         `CCC_CMD_RFC: cmd_words = `CCC_N_R;
         `CCC_CMD_XFC: cmd_words = `CCC_N_X;
         `CCC_CMD_BFC: cmd_words = `CCC_N_B;
         `CCC_CMD_ZFC: cmd_words = `CCC_N_Z;
         default: cmd_words = 6'd0;
      endcase
   endfunction

   // Low byte arrives first, so the completed word is current byte over held byte
   assign word = {byte_data, lo_reg};
   assign n_words = cmd_words(cmd_reg);
   assign payload_byte = clk_en && byte_valid && !frame_start && state_reg == CCC_PAYLOAD;
   assign last_byte = payload_byte && cnt_reg == 6'((n_words << 1) - 6'd1);
   assign commit_rx = last_byte && cmd_reg == `CCC_CMD_GRX;
   assign commit_tout = last_byte && cmd_reg == `CCC_CMD_TOUT;
   assign commit_filter = last_byte && n_words > 6'd1;

   always_comb begin
      unique case (cmd_reg)
         `CCC_CMD_XFC: base = `CCC_BASE_X;
         `CCC_CMD_BFC: base = `CCC_BASE_B;
         `CCC_CMD_ZFC: base = `CCC_BASE_Z;
         default: base = `CCC_BASE_R;
      endcase
   end

   always_comb begin
      state_next = state_reg;
      cmd_next = cmd_reg;
      cnt_next = cnt_reg;
      lo_next = lo_reg;
      afe_next = afe_reg;
      tout_next = tout_reg;
      rx_gain_next = rx_gain_reg;
      tx_gain_next = tx_gain_reg;
      if (byte_valid && frame_start) begin
         // A new frame aborts any unfinished command, nothing of it is kept
         cmd_next = byte_data[6:0];
         cnt_next = 6'd0;
         state_next = (!byte_data[7] && cmd_words(byte_data[6:0]) != 6'd0) ? CCC_PAYLOAD : CCC_SKIP;
      end else if (byte_valid) begin
         unique case (state_reg)
            CCC_PAYLOAD: begin
               lo_next = byte_data;
               cnt_next = 6'(cnt_reg + 6'd1);
               if (last_byte) begin
                  state_next = CCC_SKIP;
               end
            end
            CCC_IDLE, CCC_SKIP: begin
            end
            default: state_next = CCC_IDLE;
         endcase
      end
      if (last_byte) begin
         if (cmd_reg == `CCC_CMD_AFE) begin
            afe_next = word;
         end
         if (commit_tout) begin
            tout_next = word;
         end
         for (int ch = 0; ch < `CCC_CHANNELS; ch++) begin
            if (channel_enable_mask[ch]) begin
               if (commit_rx) begin
                  rx_gain_next[ch] = word;
               end
               if (cmd_reg == `CCC_CMD_GTX) begin
                  tx_gain_next[ch] = word;
               end
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg <= CCC_IDLE;
         cmd_reg <= 7'h00;
         cnt_reg <= 6'd0;
         lo_reg <= 8'h00;
         afe_reg <= `CCC_AFE_RST;
         tout_reg <= `CCC_TOUT_RST;
         done_reg <= 1'b0;
         for (int ch = 0; ch < `CCC_CHANNELS; ch++) begin
            rx_gain_reg[ch] <= `CCC_GAIN_RST;
            tx_gain_reg[ch] <= `CCC_GAIN_RST;
         end
      end else if (clk_en) begin
         state_reg <= state_next;
         cmd_reg <= cmd_next;
         cnt_reg <= cnt_next;
         lo_reg <= lo_next;
         afe_reg <= afe_next;
         tout_reg <= tout_next;
         done_reg <= last_byte;
         rx_gain_reg <= rx_gain_next;
         tx_gain_reg <= tx_gain_next;
      end
   end

   // Filter words are staged so a channel never runs on a half-loaded set
   always_ff @(posedge clock) begin
      if (payload_byte && cnt_reg[0] && !last_byte) begin
         stage_reg[cnt_reg[5:1]] <= word;
      end
      if (commit_filter) begin
         for (int ch = 0; ch < `CCC_CHANNELS; ch++) begin
            for (int i = 0; i < `CCC_STAGE_WORDS; i++) begin
               if (channel_enable_mask[ch] && 6'(i) < n_words) begin
                  coef_mem[ch][7'(base + 7'(i))] <= (6'(i) == 6'(n_words - 6'd1)) ? word : stage_reg[i];
               end
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         coef_rd_reg <= 16'h0000;
      end else if (clk_en) begin
         coef_rd_reg <= (coef_rd_index < 7'(`CCC_COEF_TOTAL)) ? coef_mem[coef_rd_chan][coef_rd_index] : 16'h0000;
      end
   end

   assign cmd_done = done_reg;
   assign coef_rd_data = coef_rd_reg;
   assign metering_pulse_mode = afe_reg[`CCC_TTX_BIT];
   assign timeout_setting = tout_reg;
   assign timeout_enable_bit = tout_reg[`CCC_TEN_BIT];
   assign timeout_expired = exp_reg;

   // Step of 62.5 ns is 12.5 cycles, so work in half cycles and round down
   assign tmr_target = 20'((20'(tout_reg[15:1]) * 20'(`CCC_STEP_HALF)) >> 1) + 20'(`CCC_OFS_CYC);

   always_comb begin
      tmr_cnt_next = tmr_cnt_reg;
      tmr_run_next = tmr_run_reg;
      exp_next = 1'b0;
      if (!timeout_enable_bit) begin
         tmr_run_next = 1'b0;
      end else if (timeout_start) begin
         tmr_cnt_next = 20'd0;
         tmr_run_next = 1'b1;
      end else if (tmr_run_reg) begin
         if (tmr_cnt_reg >= 20'(tmr_target - 20'd1)) begin
            exp_next = 1'b1;
            tmr_run_next = 1'b0;
         end else begin
            tmr_cnt_next = 20'(tmr_cnt_reg + 20'd1);
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tmr_cnt_reg <= 20'd0;
         tmr_run_reg <= 1'b0;
         exp_reg <= 1'b0;
      end else if (clk_en) begin
         tmr_cnt_reg <= tmr_cnt_next;
         tmr_run_reg <= tmr_run_next;
         exp_reg <= exp_next;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `CCC_CHANNELS; g++) begin : g_chan
         logic signed [31:0] rx_prod, tx_prod;
         logic signed [15:0] rx_next, tx_next;
         logic signed [15:0] rx_out_reg, tx_out_reg;
         // Two-bit field per channel in the upper byte
         assign frontend_gain_enable[g] = afe_reg[`CCC_KA_LSB + 2 * g + 1];
         assign frontend_gain_high[g] = afe_reg[`CCC_KA_LSB + 2 * g + 1] & afe_reg[`CCC_KA_LSB + 2 * g];
         always_comb begin
            rx_prod = rx_sample_in[g] * $signed(rx_gain_reg[g]);
            tx_prod = tx_sample_in[g] * $signed(tx_gain_reg[g]);
            rx_next = (rx_gain_reg[g] == 16'h0000) ? 16'sh0000 : rx_prod[30:15];
            tx_next = (tx_gain_reg[g] == 16'h0000) ? 16'sh0000 : tx_prod[30:15];
         end
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               rx_out_reg <= 16'sh0000;
               tx_out_reg <= 16'sh0000;
            end else if (clk_en) begin
               rx_out_reg <= rx_next;
               tx_out_reg <= tx_next;
            end
         end
         assign receive_analog_output[g] = rx_out_reg;
         assign pcm_transmit_output[g] = tx_out_reg;
      end
   endgenerate

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence s_commit_tout;
      commit_tout;
   endsequence
   sequence s_tout_seen;
      ##1 timeout_setting == $past(word);
   endsequence

   chk_tout_order: assert property (s_commit_tout |-> s_tout_seen) else $error("timeout word not low byte first");
   chk_mask_ignored: assert property (commit_tout && channel_enable_mask == 4'h0 |=> timeout_setting == $past(word))
      else $error("timeout command gated by mask");
   chk_fe_decode: assert property (frontend_gain_high != 4'h0 |-> (frontend_gain_high & ~frontend_gain_enable) == 4'h0)
      else $error("high gain without enable");
   chk_meter_change: assert property ($changed(metering_pulse_mode) |-> $past(last_byte) && $past(cmd_reg) == `CCC_CMD_AFE)
      else $error("metering mode changed without command");
   chk_tout_off: assert property (!timeout_enable_bit |=> !timeout_expired) else $error("timeout fired while disabled");
   chk_tout_length: assert property (timeout_expired |-> $past(tmr_cnt_reg) == 20'($past(tmr_target) - 20'd1))
      else $error("timeout length wrong");
   chk_rx_block: assert property (clk_en && rx_gain_reg[0] == 16'h0000 |=> receive_analog_output[0] == 16'sh0000)
      else $error("receive not blocked on zero gain");
   chk_tx_null: assert property (clk_en && tx_gain_reg[3] == 16'h0000 |=> pcm_transmit_output[3] == 16'sh0000)
      else $error("transmit not null on zero gain");
   chk_mask_gate: assert property (commit_rx && !channel_enable_mask[2] |=> $stable(rx_gain_reg[2]))
      else $error("masked channel updated");
   chk_gain_commit: assert property ($changed(rx_gain_reg[0]) |-> $past(commit_rx) && $past(channel_enable_mask[0]))
      else $error("gain changed before command end");
endmodule

// ---- testbench/ccc_host_model.sv ----
`timescale 1ns/1ps
module ccc_host_model (
   // Clock
   input wire logic clock,
   // Command byte stream
   output logic frame_start,
   output logic byte_valid,
   output logic [7:0] byte_data
);
   initial begin
      frame_start = 1'b0;
      byte_valid = 1'b0;
      byte_data = 8'hFF;
   end
   // Sends nb bytes: command byte then words; gap idle cycles between bytes stall the unit
   task automatic send(input logic [7:0] id, input logic [15:0] w [64], input int nb, input int gap);
      logic [7:0] b;
      b = id;
      for (int i = 0; i < nb; i++) begin
         b = (i == 0) ? id : (i[0] ? w[(i - 1) / 2][7:0] : w[(i - 1) / 2][15:8]);
         @(posedge clock);
         frame_start <= (i == 0);
         byte_valid <= 1'b1;
         byte_data <= b;
         if (gap > 0 && i < nb - 1) begin
            @(posedge clock);
            byte_valid <= 1'b0;
            byte_data <= ~b;
            repeat (gap - 1) @(posedge clock);
         end
      end
      @(posedge clock);
      frame_start <= 1'b0;
      byte_valid <= 1'b0;
      // Released line shows the inverse so a stale byte cannot pass
      byte_data <= ~b;
   endtask
endmodule

// ---- testbench/ccc_command_unit_tb.sv ----
`timescale 1ns/1ps
`include "ccc_consts.svh"
module ccc_command_unit_tb;
   import ccc_pkg::*;
   logic clock, rstn, clk_en, frame_start, byte_valid, cmd_done, timeout_start, timeout_expired;
   logic metering_pulse_mode, timeout_enable_bit;
   logic [7:0] byte_data;
   ccc_mask_t channel_enable_mask, frontend_gain_enable, frontend_gain_high;
   ccc_word_t timeout_setting, coef_rd_data;
   logic signed [15:0] rx_in [4], tx_in [4], rx_out [4], tx_out [4];
   logic [1:0] coef_rd_chan;
   logic [6:0] coef_rd_index;
   logic [15:0] w [64];
   int fails, compares;
   ccc_host_model i_host (.clock(clock), .frame_start(frame_start), .byte_valid(byte_valid),
      .byte_data(byte_data));
   ccc_command_unit i_dut (.clock(clock), .rstn(rstn), .clk_en(clk_en), .frame_start(frame_start),
      .byte_valid(byte_valid), .byte_data(byte_data), .cmd_done(cmd_done),
      .channel_enable_mask(channel_enable_mask), .frontend_gain_enable(frontend_gain_enable),
      .frontend_gain_high(frontend_gain_high), .metering_pulse_mode(metering_pulse_mode),
      .timeout_setting(timeout_setting), .timeout_enable_bit(timeout_enable_bit),
      .timeout_start(timeout_start), .timeout_expired(timeout_expired), .rx_sample_in(rx_in),
      .tx_sample_in(tx_in), .receive_analog_output(rx_out), .pcm_transmit_output(tx_out),
      .coef_rd_chan(coef_rd_chan), .coef_rd_index(coef_rd_index), .coef_rd_data(coef_rd_data));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cmd(input logic [6:0] id, input ccc_mask_t m, input int nb, input int gap, input logic done);
      @(posedge clock);
      channel_enable_mask <= m;
      i_host.send({1'b0, id}, w, nb, gap);
      #1;
      check("cmd_done", cmd_done, done);
   endtask
   task automatic rd(input logic [1:0] ch, input int idx, input logic [15:0] exp);
      @(posedge clock);
      coef_rd_chan <= ch;
      coef_rd_index <= idx[6:0];
      @(posedge clock);
      #1;
      check("coef", coef_rd_data, exp);
   endtask
   task automatic t_reset();
      check("tout_rst", timeout_setting, 16'hFFFF);
      check("ten_rst", timeout_enable_bit, 1'b1);
      check("fe_en_rst", frontend_gain_enable, 4'hF);
      check("fe_hi_rst", frontend_gain_high, 4'h0);
      $display("reset test done");
   endtask
   task automatic t_frontend();
      // Channel 0 off, 1 off with low bit set, 2 low, 3 high, metering on
      w[0] = 16'hE401;
      cmd(`CCC_CMD_AFE, 4'h0, 3, 0, 1'b1);
      check("fe_en", frontend_gain_enable, 4'b1100);
      check("fe_hi", frontend_gain_high, 4'b1000);
      check("meter", metering_pulse_mode, 1'b1);
      w[0] = 16'h5500;
      cmd(`CCC_CMD_AFE, 4'h0, 3, 0, 1'b1);
      check("fe_en0", frontend_gain_enable, 4'b0000);
      check("meter0", metering_pulse_mode, 1'b0);
      $display("frontend test done");
   endtask
   task automatic t_timeout();
      int k;
      int hit;
      w[0] = 16'h0005;
      cmd(`CCC_CMD_TOUT, 4'h0, 3, 0, 1'b1);
      check("tout", timeout_setting, 16'h0005);
      @(posedge clock) timeout_start <= 1'b1;
      @(posedge clock) timeout_start <= 1'b0;
      for (k = 1; k <= 100; k++) begin
         @(posedge clock);
         #1;
         if (timeout_expired === 1'b1) break;
      end
      // Half-cycle steps rounded down, counted from the edge that takes the start pulse
      check("expire_at", k, ((5 >> 1) * `CCC_STEP_HALF) / 2 + `CCC_OFS_CYC);
      if (k > 100) close_out();
      w[0] = 16'h0004;
      cmd(`CCC_CMD_TOUT, 4'h0, 3, 0, 1'b1);
      check("ten", timeout_enable_bit, 1'b0);
      hit = 0;
      @(posedge clock) timeout_start <= 1'b1;
      @(posedge clock) timeout_start <= 1'b0;
      repeat (60) begin
         @(posedge clock);
         #1;
         if (timeout_expired !== 1'b0) hit++;
      end
      check("no_expire", hit, 0);
      $display("timeout test done");
   endtask
   task automatic t_gain();
      w[0] = 16'h2000;
      cmd(`CCC_CMD_GRX, 4'b0101, 3, 1, 1'b1);
      // Refused: read flag, unknown id, and a command cut short by the next frame
      i_host.send({1'b1, `CCC_CMD_GRX}, w, 3, 0);
      i_host.send(8'h7F, w, 3, 0);
      w[0] = 16'h0000;
      cmd(`CCC_CMD_GRX, 4'hF, 2, 0, 1'b0);
      @(posedge clock);
      #1;
      for (int c = 0; c < 4; c++) check("rx_out", rx_out[c], c[0] ? 16'h0800 : 16'h0400);
      // Zero gain is only the digital half of opening the loop; the amplifier mute is the host's
      cmd(`CCC_CMD_GRX, 4'b0001, 3, 0, 1'b1);
      w[0] = 16'h7FFF;
      cmd(`CCC_CMD_GTX, 4'b0001, 3, 0, 1'b1);
      w[0] = 16'h0000;
      cmd(`CCC_CMD_GTX, 4'b1000, 3, 0, 1'b1);
      @(posedge clock);
      #1;
      check("rx0", rx_out[0], 16'h0000);
      check("rx2", rx_out[2], 16'h0400);
      check("tx0", tx_out[0], 16'h0FFF);
      check("tx1", tx_out[1], 16'h0800);
      check("tx3", tx_out[3], 16'h0000);
      $display("gain test done");
   endtask
   task automatic t_hold();
      // A whole command offered while the enable is low must leave every setting alone
      @(posedge clock) clk_en <= 1'b0;
      w[0] = 16'h0000;
      cmd(`CCC_CMD_GTX, 4'hF, 3, 0, 1'b0);
      @(posedge clock) clk_en <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      check("hold_tx1", tx_out[1], 16'h0800);
      check("hold_rx2", rx_out[2], 16'h0400);
      $display("hold test done");
   endtask
   task automatic t_filter();
      logic [6:0] ids [4] = '{`CCC_CMD_RFC, `CCC_CMD_XFC, `CCC_CMD_BFC, `CCC_CMD_ZFC};
      int n [4] = '{`CCC_N_R, `CCC_N_X, `CCC_N_B, `CCC_N_Z};
      int base [4] = '{`CCC_BASE_R, `CCC_BASE_X, `CCC_BASE_B, `CCC_BASE_Z};
      for (int f = 0; f < 4; f++) begin
         for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 64; k++) w[k] = {p[3:0], f[3:0], k[7:0]};
            cmd(ids[f], p[0] ? 4'b0010 : 4'b1111, 2 * n[f] + 1, (f == 2) ? 1 : 0, 1'b1);
         end
         for (int k = 0; k < n[f]; k++) begin
            rd(2'd1, base[f] + k, {4'h1, f[3:0], k[7:0]});
            rd(2'd0, base[f] + k, {4'h0, f[3:0], k[7:0]});
         end
      end
      rd(2'd1, `CCC_COEF_TOTAL, 16'h0000);
      $display("filter test done");
   endtask
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      fails = 0;
      compares = 0;
      rstn = 1'b0;
      clk_en = 1'b1;
      timeout_start = 1'b0;
      channel_enable_mask = 4'h0;
      coef_rd_chan = 2'd0;
      coef_rd_index = 7'd0;
      for (int c = 0; c < 4; c++) begin
         rx_in[c] = 16'sh1000;
         tx_in[c] = 16'sh1000;
      end
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      #1;
      t_reset();
      t_frontend();
      t_timeout();
      t_gain();
      t_hold();
      t_filter();
      close_out();
   end
endmodule
